// ===== mrr_pkg.sv
// package for the measurement result register bank
// assumes a single 100 MHz clock and an AXI4-Lite register bus
package mrr_pkg;
   localparam int          MRR_NUM_CELLS        = 14;
   localparam int          MRR_CODE_W           = 14;
   localparam int          MRR_CODE_LSB         = 2;
   localparam int          MRR_AW               = 9;
   // printed offsets are not word multiples: they are indices, byte = 4*index
   localparam logic [7:0]  MRR_IDX_BLOCK        = 8'h55;
   localparam logic [7:0]  MRR_IDX_TOTAL        = 8'h56;
   localparam logic [7:0]  MRR_IDX_DIAG_A       = 8'h57;
   localparam logic [7:0]  MRR_IDX_DIAG_B       = 8'h58;
   localparam logic [7:0]  MRR_IDX_AUXILIARY_INPUT0_CODE         = 8'h59;
   localparam logic [7:0]  MRR_IDX_CTRL         = 8'h60;
   localparam logic [15:0] MRR_RST_RESULT       = 16'h0000;
   localparam logic [15:0] MRR_RST_CTRL         = 16'h0000;
   // control register field positions
   localparam int          MRR_CTRL_BLOCK_EN    = 0;
   localparam int          MRR_CTRL_AUX_EN      = 1;
   localparam int          MRR_CTRL_AUX_PIN     = 2;
   localparam int          MRR_CTRL_FILTERED_READBACK_SELECT      = 3;
   localparam int          MRR_CTRL_W           = 4;
   localparam logic [1:0]  MRR_RESP_OKAY        = 2'b00;
   localparam logic [1:0]  MRR_RESP_SLVERR      = 2'b10;
   typedef enum logic [1:0] {MRR_IDLE, MRR_SUM, MRR_COMMIT} mrr_state_type;
endpackage : mrr_pkg

// ===== mrr_regs.sv
// measurement result register bank: results land at scan end, read over AXI4-Lite
// assumes the acquisition engine presents one scan's results with a scan_done pulse; block_filtered_code is sampled at commit, 15 cycles later
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ns
module mrr_regs
   import mrr_pkg::*;
(
   input  wire logic                              clk,
   input  wire logic                              rst,
   input  wire logic                              scan_done,
   input  wire logic [MRR_NUM_CELLS-1:0]          cell_measure_enable_set,
   input  wire logic [MRR_NUM_CELLS-1:0]          cell_bipolar,
   input  wire logic [MRR_NUM_CELLS*16-1:0]       cell_sum_term,
   input  wire logic                              block_measured,
   input  wire logic [mrr_pkg::MRR_CODE_W-1:0]    module_block_voltage_code,
   input  wire logic [mrr_pkg::MRR_CODE_W-1:0]    block_filtered_code,
   input  wire logic [mrr_pkg::MRR_CODE_W-1:0]    diagnostic_code_a,
   input  wire logic [mrr_pkg::MRR_CODE_W-1:0]    diagnostic_code_b,
   input  wire logic                              aux_measured,
   input  wire logic [mrr_pkg::MRR_CODE_W-1:0]    auxiliary_input0_code,
   output logic                                   sum_busy,
   input  wire logic [mrr_pkg::MRR_AW-1:0]        s_axi_awaddr,
   input  wire logic                              s_axi_awvalid,
   output logic                                   s_axi_awready,
   input  wire logic [31:0]                       s_axi_wdata,
   input  wire logic [3:0]                        s_axi_wstrb,
   input  wire logic                              s_axi_wvalid,
   output logic                                   s_axi_wready,
   output logic [1:0]                             s_axi_bresp,
   output logic                                   s_axi_bvalid,
   input  wire logic                              s_axi_bready,
   input  wire logic [mrr_pkg::MRR_AW-1:0]        s_axi_araddr,
   input  wire logic                              s_axi_arvalid,
   output logic                                   s_axi_arready,
   output logic [31:0]                            s_axi_rdata,
   output logic [1:0]                             s_axi_rresp,
   output logic                                   s_axi_rvalid,
   input  wire logic                              s_axi_rready
);
   import mrr_pkg::*;

   function automatic logic [7:0] word_index(input logic [MRR_AW-1:0] a);
      word_index = {1'b0, a[MRR_AW-1:2]};
   endfunction : word_index

   mrr_state_type                state_r;
   logic [3:0]                   cell_idx_r;
   // 21 bits: fourteen full-scale unsigned terms must not wrap negative
   logic signed [20:0]           acc_r;
   logic [MRR_NUM_CELLS-1:0]     en_r;
   logic [MRR_NUM_CELLS-1:0]     bip_r;
   logic [MRR_NUM_CELLS*16-1:0]  term_r;
   logic                         blk_upd_r;
   logic                         aux_upd_r;
   logic [MRR_CODE_W-1:0]        blk_cap_r;
   logic [MRR_CODE_W-1:0]        dga_cap_r;
   logic [MRR_CODE_W-1:0]        dgb_cap_r;
   logic [MRR_CODE_W-1:0]        aux_cap_r;
   logic [MRR_CODE_W-1:0]        blk_code_r;
   logic [MRR_CODE_W-1:0]        blk_filt_r;
   logic [15:0]                  total_r;
   logic [MRR_CODE_W-1:0]        dga_code_r;
   logic [MRR_CODE_W-1:0]        dgb_code_r;
   logic [MRR_CODE_W-1:0]        aux_code_r;
   logic [MRR_CTRL_W-1:0]        ctrl_r;
   logic                         aw_held_r;
   logic                         w_held_r;
   logic [MRR_AW-1:0]            awaddr_r;
   logic [31:0]                  wdata_r;
   logic [3:0]                   wstrb_r;
   logic signed [20:0]           term_nxt;
   logic [15:0]                  rd_nxt;
   logic                         rd_ok_nxt;
   logic [15:0]                  cur_term;

   // one cell per cycle keeps the adder small; a scan takes 15 cycles to commit
   always_comb
   begin
      cur_term = term_r[cell_idx_r*16 +: 16];
      if (!en_r[cell_idx_r])
         term_nxt = '0;
      else if (bip_r[cell_idx_r])
         term_nxt = 21'(signed'(cur_term));
      else
         term_nxt = {5'h00, cur_term};
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_r    <= MRR_IDLE;
         cell_idx_r <= '0;
         acc_r      <= '0;
         en_r       <= '0;
         bip_r      <= '0;
         term_r     <= '0;
         blk_upd_r  <= 1'b0;
         aux_upd_r  <= 1'b0;
         blk_cap_r  <= '0;
         dga_cap_r  <= '0;
         dgb_cap_r  <= '0;
         aux_cap_r  <= '0;
         sum_busy   <= 1'b0;
      end
      else
      begin
         case (state_r)
            MRR_IDLE:
            begin
               if (scan_done)
               begin
                  en_r       <= cell_measure_enable_set;
                  bip_r      <= cell_bipolar;
                  term_r     <= cell_sum_term;
                  blk_upd_r  <= block_measured;
                  aux_upd_r  <= aux_measured;
                  blk_cap_r  <= module_block_voltage_code;
                  dga_cap_r  <= diagnostic_code_a;
                  dgb_cap_r  <= diagnostic_code_b;
                  aux_cap_r  <= auxiliary_input0_code;
                  cell_idx_r <= '0;
                  acc_r      <= '0;
                  sum_busy   <= 1'b1;
                  state_r    <= MRR_SUM;
               end
            end
            MRR_SUM:
            begin
               acc_r <= acc_r + term_nxt;
               if (cell_idx_r == 4'(MRR_NUM_CELLS - 1))
                  state_r <= MRR_COMMIT;
               else
                  cell_idx_r <= cell_idx_r + 4'h1;
            end
            MRR_COMMIT:
            begin
               sum_busy <= 1'b0;
               state_r  <= MRR_IDLE;
            end
            default:
               state_r <= MRR_IDLE;
         endcase
      end
   end

   // all results of a scan commit in the same cycle
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         total_r    <= MRR_RST_RESULT;
         blk_code_r <= '0;
         blk_filt_r <= '0;
         dga_code_r <= '0;
         dgb_code_r <= '0;
         aux_code_r <= '0;
      end
      else if (state_r == MRR_COMMIT)
      begin
         if (acc_r < 0)
            total_r <= 16'h0000;
         else if (acc_r > 21'sh00FFFF)
            total_r <= 16'hFFFF;
         else
            total_r <= acc_r[15:0];
         if (blk_upd_r)
         begin
            blk_code_r <= blk_cap_r;
            blk_filt_r <= block_filtered_code;
         end
         dga_code_r <= dga_cap_r;
         dgb_code_r <= dgb_cap_r;
         if (aux_upd_r)
            aux_code_r <= aux_cap_r;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         ctrl_r <= MRR_CTRL_W'(MRR_RST_CTRL);
      else if (aw_held_r && w_held_r && !s_axi_bvalid && word_index(awaddr_r) == MRR_IDX_CTRL && wstrb_r[0])
         ctrl_r <= wdata_r[MRR_CTRL_W-1:0];
   end

   // write path: address and data taken in either order, response after both
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         aw_held_r     <= 1'b0;
         w_held_r      <= 1'b0;
         awaddr_r      <= '0;
         wdata_r       <= '0;
         wstrb_r       <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= MRR_RESP_OKAY;
      end
      else
      begin
         s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_held_r && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
         end
         if (aw_held_r && w_held_r && !s_axi_bvalid)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (word_index(awaddr_r) == MRR_IDX_CTRL) ? MRR_RESP_OKAY : MRR_RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            aw_held_r    <= 1'b0;
            w_held_r     <= 1'b0;
         end
      end
   end

   always_comb
   begin
      rd_ok_nxt = 1'b1;
      case (word_index(s_axi_araddr))
         MRR_IDX_BLOCK:
            rd_nxt = {(ctrl_r[MRR_CTRL_FILTERED_READBACK_SELECT] ? blk_filt_r : blk_code_r), 2'b00};
         MRR_IDX_TOTAL:
            rd_nxt = total_r;
         MRR_IDX_DIAG_A:
            rd_nxt = {dga_code_r, 2'b00};
         MRR_IDX_DIAG_B:
            rd_nxt = {dgb_code_r, 2'b00};
         MRR_IDX_AUXILIARY_INPUT0_CODE:
            rd_nxt = ctrl_r[MRR_CTRL_AUX_PIN] ? {aux_code_r, 2'b00} : 16'h0000;
         MRR_IDX_CTRL:
            rd_nxt = {12'h000, ctrl_r};
         default:
         begin
            rd_nxt    = 16'h0000;
            rd_ok_nxt = 1'b0;
         end
      endcase
   end

   // reads only sample state, nothing clears on read
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= MRR_RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {16'h0000, rd_nxt};
            s_axi_rresp  <= rd_ok_nxt ? MRR_RESP_OKAY : MRR_RESP_SLVERR;
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end
endmodule : mrr_regs

// ===== mrr_regs_checker.sv
// port checker for the measurement result register bank
// assumes it is bound onto mrr_regs, single clock, rst active high
`timescale 1ns/1ns
module mrr_regs_checker
   import mrr_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        scan_done,
   input wire logic        sum_busy,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_bvalid
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_busy_start; scan_done && !sum_busy |=> sum_busy; endproperty
   a_busy_start: assert property (p_busy_start) else $error("scan not started");
   // fifteen busy cycles, then results commit
   property p_busy_len; $rose(sum_busy) |-> sum_busy[*8] ##1 sum_busy[*7] ##1 !sum_busy; endproperty
   a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
   property p_busy_idle; !sum_busy && !scan_done |=> !sum_busy; endproperty
   a_busy_idle: assert property (p_busy_idle) else $error("busy without scan");
   property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
   property p_rdata_hi; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
   a_rdata_hi: assert property (p_rdata_hi) else $error("upper read bits set");
   property p_ar_pulse; s_axi_arready |=> !s_axi_arready; endproperty
   a_ar_pulse: assert property (p_ar_pulse) else $error("arready not a pulse");
   property p_wr_ans; s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid; endproperty
   a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
   property p_err_zero; s_axi_rvalid && s_axi_rresp != MRR_RESP_OKAY |-> s_axi_rdata == 32'h0000_0000; endproperty
   a_err_zero: assert property (p_err_zero) else $error("error read data");
   c_scan: cover property ($rose(sum_busy));
   c_slverr: cover property (s_axi_rvalid && s_axi_rresp == MRR_RESP_SLVERR);
   c_write: cover property (s_axi_bvalid);
endmodule : mrr_regs_checker
bind mrr_regs mrr_regs_checker mrr_regs_checker_inst (.*);

// ===== test_mrr_regs.sv
// self-checking bench for the measurement result register bank
// assumes mrr_pkg and the checker are compiled first
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module test_mrr_regs;
   import mrr_pkg::*;
   logic clk = 0, rst = 1, scan_done = 0, block_measured = 0, aux_measured = 0, sum_busy;
   logic [13:0]  cell_measure_enable_set = 0, cell_bipolar = 0, module_block_voltage_code = 0, block_filtered_code = 0;
   logic [13:0]  diagnostic_code_a = 0, diagnostic_code_b = 0, auxiliary_input0_code = 0;
   logic [223:0] cell_sum_term = 0;
   logic [8:0]   s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0]  s_axi_wdata = 0, s_axi_rdata;
   logic [3:0]   s_axi_wstrb = 0, ctrl = 0;
   // ready lines held high: no driver toggling between transfers
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1, s_axi_arvalid = 0, s_axi_rready = 1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]   s_axi_bresp, s_axi_rresp;
   logic [13:0]  m_blk = 0, m_filt = 0, m_aux = 0, m_da = 0, m_db = 0;
   logic [15:0]  m_tot = 0;
   int err_count = 0, num_checks = 0, cyc = 0, k;
   mrr_regs mrr_regs_inst (.*);
   always #5 clk = ~clk;
   task end_of_test;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         err_count++;
         end_of_test();
      end
   end
   task rd(input logic [8:0] a, input logic [31:0] e, input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      do @(posedge clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 0;
      do @(posedge clk); while (s_axi_rvalid !== 1'b1);
      `CHK(s_axi_rdata, e)
      `CHK(s_axi_rresp, er)
   endtask : rd
   task wr(input logic [8:0] a, input logic [31:0] v, input logic [1:0] er);
      bit ta, tw;
      ta = 0;
      tw = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      do
      begin
         @(posedge clk);
         if (s_axi_awready === 1'b1)
         begin
            ta = 1;
            s_axi_awvalid <= 0;
         end
         if (s_axi_wready === 1'b1)
         begin
            tw = 1;
            s_axi_wvalid <= 0;
         end
      end while (!(ta && tw));
      do @(posedge clk); while (s_axi_bvalid !== 1'b1);
      `CHK(s_axi_bresp, er)
   endtask : wr
   task rd_all;
      rd(9'h154, {16'h0, ctrl[3] ? m_filt : m_blk, 2'b00}, MRR_RESP_OKAY);
      rd(9'h158, {16'h0, m_tot}, MRR_RESP_OKAY);
      rd(9'h15C, {16'h0, m_da, 2'b00}, MRR_RESP_OKAY);
      rd(9'h160, {16'h0, m_db, 2'b00}, MRR_RESP_OKAY);
      rd(9'h164, {16'h0, ctrl[2] ? m_aux : 14'h0, 2'b00}, MRR_RESP_OKAY);
   endtask : rd_all
   // mode 1 forces a negative total, mode 2 an overflowing one
   task scan(input int mode);
      logic [13:0] en, bp, cb, cf, ca;
      logic [15:0] t;
      logic bm, am;
      int s;
      en = mode > 0 ? 14'h3FFF : 14'($urandom);
      bp = mode == 1 ? 14'h3FFF : mode == 2 ? 14'h0 : 14'($urandom);
      bm = 1'($urandom);
      am = ctrl[2] & 1'($urandom);
      s = 0;
      for (int i = 0; i < 14; i++)
      begin
         t = mode == 1 ? 16'hF000 : mode == 2 ? 16'hFFFF : 16'($urandom & 32'h1FFF);
         if (mode == 0 && bp[i] && $urandom % 2)
            t = -t;
         cell_sum_term[16*i +: 16] <= t;
         if (en[i])
            s += bp[i] ? int'($signed(t)) : int'(t);
      end
      cb = 14'($urandom);
      cf = 14'($urandom);
      ca = 14'($urandom);
      cell_measure_enable_set <= en;
      cell_bipolar <= bp;
      block_measured <= bm;
      aux_measured <= am;
      module_block_voltage_code <= cb;
      block_filtered_code <= cf;
      auxiliary_input0_code <= ca;
      m_da = 14'($urandom);
      m_db = 14'($urandom);
      diagnostic_code_a <= m_da;
      diagnostic_code_b <= m_db;
      scan_done <= 1;
      @(posedge clk);
      scan_done <= 0;
      do @(posedge clk); while (sum_busy !== 1'b0);
      m_tot = s < 0 ? 16'h0000 : s > 65535 ? 16'hFFFF : s[15:0];
      m_blk = bm ? cb : m_blk;
      m_filt = bm ? cf : m_filt;
      m_aux = am ? ca : m_aux;
   endtask : scan
   initial
   begin
      void'($urandom(32'h5859));
      repeat (3) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      rd(9'h1FC, 32'h0, MRR_RESP_SLVERR);
      wr(9'h158, 32'hFFFF, MRR_RESP_SLVERR);
      rd_all();
      for (k = 0; k < 20; k++)
      begin
         ctrl = 4'($urandom);
         wr(9'h180, {28'h0, ctrl}, MRR_RESP_OKAY);
         rd(9'h180, {28'h0, ctrl}, MRR_RESP_OKAY);
         scan(k < 3 ? k : 0);
         rd_all();
      end
      end_of_test();
   end
endmodule : test_mrr_regs
